// ---- core/dsr_pkg.sv ----
// Package for the DDR2 self refresh control block.
// Assumes a 100 MHz mclk and command pins that arrive outside mclk and are synchronised to it.
package dsr_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int DLL_RELOCK_CYCLES = 200;
  localparam int CKE_REGISTRATIONS = 4;
  localparam int INT_REFRESH_PERIOD_NS = 7800;
  localparam int INT_REFRESH_CYCLES = INT_REFRESH_PERIOD_NS / CLK_PERIOD_NS;
  localparam int REFRESH_BUSY_CYCLES = 8;
  localparam logic [11:0] RELOCK_LAST = 12'(DLL_RELOCK_CYCLES - 1);
  localparam logic [11:0] INTREF_LAST = 12'(INT_REFRESH_CYCLES - 1);
  localparam logic [11:0] BUSY_LAST = 12'(REFRESH_BUSY_CYCLES - 1);

  // ----------------------------------------
  // Command encodings {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_REFRESH = 4'h1;

  // ----------------------------------------
  // Termination field positions and codes {A6, A2}
  // ----------------------------------------
  localparam int ODT_HI_BIT = 6;
  localparam int ODT_LO_BIT = 2;
  localparam logic [1:0] ODT_OFF = 2'h0;
  localparam logic [1:0] ODT_75 = 2'h1;
  localparam logic [1:0] ODT_150 = 2'h2;
  localparam logic [1:0] ODT_50 = 2'h3;
  localparam logic [2:0] EMR_BANK = 3'h1;
  localparam logic [3:0] CMD_MODE_SET = 4'h0;

  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [3:0] {
    DSR_ACTIVE = 4'h1,
    DSR_SELF = 4'h2,
    DSR_EXIT = 4'h4,
    DSR_RELOCK = 4'h8
  } dsr_state_t;

endpackage

// ---- core/dsr_refresh_timer.sv ----
// Internal refresh timer used while in self refresh.
// Assumes the enable comes from the controlling state machine on mclk.
`timescale 1ns/1ps
module dsr_refresh_timer
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Control
  input wire logic enable,
  // Status
  output logic refresh_busy,
  output logic refresh_tick
);
  import dsr_pkg::*;

  logic [11:0] count;
  logic [11:0] busy_count;
  logic [11:0] next_count;
  logic [11:0] next_busy_count;
  logic next_refresh_busy;
  logic next_refresh_tick;

  // ----------------------------------------
  // Interval and busy window
  // ----------------------------------------
  always_comb
  begin
    next_count = count;
    next_busy_count = busy_count;
    next_refresh_busy = refresh_busy;
    next_refresh_tick = 1'b0;
    if (enable && count == INTREF_LAST)
    begin
      next_count = '0;
      next_refresh_tick = 1'b1;
      next_refresh_busy = 1'b1;
      next_busy_count = '0;
    end
    else if (enable)
      next_count = count + 12'h001;
    else
      next_count = '0;
    // A refresh in progress is allowed to complete after enable drops.
    if (refresh_busy && !next_refresh_tick)
    begin
      if (busy_count == BUSY_LAST)
        next_refresh_busy = 1'b0;
      else
        next_busy_count = busy_count + 12'h001;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count <= '0;
      busy_count <= '0;
      refresh_busy <= 1'b0;
      refresh_tick <= 1'b0;
    end
    else
    begin
      count <= next_count;
      busy_count <= next_busy_count;
      refresh_busy <= next_refresh_busy;
      refresh_tick <= next_refresh_tick;
    end
  end

endmodule

// ---- core/dsr_self_refresh_ctrl.sv ----
// Self refresh entry and exit control with on-die termination selection.
// Assumes cke and command pins come from an external controller, outside mclk.
// Contract
// - Refresh command with CKE low enters self refresh
// - Internal timer keeps contents without external clock
// - DLL off on entry, on at exit
// - All inputs except CKE ignored in self refresh; reset still forces the active state
// - EMR A6,A2 select 75, 150, 50 ohm
`timescale 1ns/1ps
module dsr_self_refresh_ctrl
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [2:0] bank,
  input wire logic [13:0] addr,
  // Status
  output logic self_refresh,
  output logic dll_enable,
  output logic read_allowed,
  output logic refresh_busy,
  output logic [1:0] odt_sel
);
  import dsr_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [21:0] pin_meta;
  logic [21:0] pin_sync;

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= {cke, cs_n, ras_n, cas_n, we_n, bank, addr};
      pin_sync <= pin_meta;
    end
  end

  logic s_cke;
  logic [3:0] s_cmd;
  logic [2:0] s_bank;
  logic [13:0] s_addr;
  assign s_cke = pin_sync[21];
  assign s_cmd = pin_sync[20:17];
  assign s_bank = pin_sync[16:14];
  assign s_addr = pin_sync[13:0];

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  dsr_state_t state;
  dsr_state_t next_state;
  logic [11:0] count;
  logic [11:0] next_count;
  logic next_self_refresh;
  logic next_dll_enable;
  logic next_read_allowed;
  logic [1:0] next_odt_sel;
  logic timer_busy;

  dsr_refresh_timer u_timer
  (
    .mclk(mclk),
    .reset(reset),
    .enable(state == DSR_SELF),
    .refresh_busy(timer_busy),
    .refresh_tick()
  );

  always_comb
  begin
    next_state = state;
    next_count = count;
    next_self_refresh = self_refresh;
    next_dll_enable = dll_enable;
    next_read_allowed = read_allowed;
    next_odt_sel = odt_sel;
    unique case (state)
      DSR_ACTIVE:
      begin
        if (!s_cke && s_cmd == CMD_REFRESH)
        begin
          next_state = DSR_SELF;
          next_self_refresh = 1'b1;
          next_dll_enable = 1'b0;
          next_read_allowed = 1'b0;
        end
        else if (s_cke && s_cmd == CMD_MODE_SET && s_bank == EMR_BANK)
          next_odt_sel = {s_addr[ODT_HI_BIT], s_addr[ODT_LO_BIT]};
      end
      DSR_SELF:
      begin
        // Only CKE is looked at here; the timer keeps the array refreshed.
        if (s_cke)
        begin
          next_state = DSR_EXIT;
          next_count = '0;
        end
      end
      DSR_EXIT:
      begin
        if (!s_cke)
          next_state = DSR_SELF;
        else if (count == 12'(CKE_REGISTRATIONS - 1))
        begin
          next_state = DSR_RELOCK;
          next_count = '0;
          next_self_refresh = 1'b0;
          next_dll_enable = 1'b1;
        end
        else
          next_count = count + 12'h001;
      end
      DSR_RELOCK:
      begin
        if (count == RELOCK_LAST)
        begin
          next_state = DSR_ACTIVE;
          next_read_allowed = 1'b1;
        end
        else
          next_count = count + 12'h001;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= DSR_ACTIVE;
      count <= '0;
      self_refresh <= 1'b0;
      dll_enable <= 1'b1;
      read_allowed <= 1'b1;
      odt_sel <= ODT_OFF;
      refresh_busy <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      self_refresh <= next_self_refresh;
      dll_enable <= next_dll_enable;
      read_allowed <= next_read_allowed;
      odt_sel <= next_odt_sel;
      refresh_busy <= timer_busy;
    end
  end

  // ----------------------------------------
  // Relock window measurement
  // ----------------------------------------
  logic [11:0] relock_run;
  logic [11:0] next_relock_run;

  // Counts consecutive cycles with the DLL on while reads are still held off.
  always_comb
  begin
    next_relock_run = '0;
    if (dll_enable && !read_allowed)
      next_relock_run = relock_run + 12'h001;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      relock_run <= '0;
    else
      relock_run <= next_relock_run;
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_entry_dll_off : assert property (@(posedge mclk) disable iff (reset)
    (state == DSR_ACTIVE && !s_cke && s_cmd == CMD_REFRESH) |=> (self_refresh && !dll_enable))
    else $error("self refresh entry did not stop the dll");

  a_self_ignores_cmd : assert property (@(posedge mclk) disable iff (reset)
    (state == DSR_SELF && !s_cke) |=> (state == DSR_SELF && $stable(odt_sel)))
    else $error("command seen during self refresh");

  a_dll_off_in_self : assert property (@(posedge mclk) disable iff (reset)
    self_refresh |-> !dll_enable)
    else $error("dll running in self refresh");

  a_exit_four_regs : assert property (@(posedge mclk) disable iff (reset)
    (state == DSR_SELF && s_cke) ##1 (s_cke [*4]) |=> !self_refresh && dll_enable)
    else $error("exit did not complete after four registrations");

  a_relock_wait : assert property (@(posedge mclk) disable iff (reset)
    $rose(read_allowed) |-> relock_run == 12'(DLL_RELOCK_CYCLES))
    else $error("read window not exactly 200 cycles after relock");

  a_relock_bound : assert property (@(posedge mclk) disable iff (reset)
    (dll_enable && !read_allowed) |-> relock_run < 12'(DLL_RELOCK_CYCLES))
    else $error("reads held off longer than the relock time");

  a_odt_decode : assert property (@(posedge mclk) disable iff (reset)
    (state == DSR_ACTIVE && s_cke && s_cmd == CMD_MODE_SET && s_bank == EMR_BANK)
    |=> odt_sel == {$past(s_addr[ODT_HI_BIT]), $past(s_addr[ODT_LO_BIT])})
    else $error("termination select not taken from a6 a2");

  a_timer_runs : assert property (@(posedge mclk) disable iff (reset)
    (state == DSR_SELF) [*1] ##0 (u_timer.count == INTREF_LAST) |=> ##1 refresh_busy)
    else $error("internal refresh did not start");

endmodule

// ---- dv/dsr_ctl_model.sv ----
// Memory controller model driving clock enable and command pins.
// Assumes mclk runs free and the bench calls its tasks.
`timescale 1ns/1ps
module dsr_ctl_model
(
  // Clock
  input wire logic mclk,
  // Command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [2:0] bank,
  output logic [13:0] addr
);
  import dsr_pkg::*;
  initial
  begin
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    bank = 3'h0;
    addr = 14'h0000;
  end
  // Pins other than cke wander through many codes, one step per cycle, while in self refresh.
  task wander(input int n);
    repeat (n)
    begin
      @(posedge mclk);
      #1;
      {bank, addr, cs_n, ras_n, cas_n, we_n} = {bank, addr, cs_n, ras_n, cas_n, we_n} + 21'h12345;
    end
  endtask
  task send(input logic k, input logic [3:0] c, input logic [2:0] b, input logic [13:0] a);
    @(posedge mclk);
    #1;
    cke = k;
    {cs_n, ras_n, cas_n, we_n} = c;
    bank = b;
    addr = a;
    @(posedge mclk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
  endtask
  task enter();
    send(1'b0, CMD_REFRESH, 3'h0, 14'h0000);
  endtask
  task glitch();
    @(posedge mclk);
    #1;
    cke = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    cke = 1'b0;
  endtask
  task leave();
    @(posedge mclk);
    #1;
    {cs_n, ras_n, cas_n, we_n} = 4'h7;
    bank = 3'h0;
    addr = 14'h0000;
    cke = 1'b1;
  endtask
endmodule

// ---- dv/ddr2_self_refresh_control_bench.sv ----
// Self-checking bench for the self refresh control block.
// Assumes the controller model drives all command pins.
`timescale 1ns/1ps
module ddr2_self_refresh_control_bench;
  import dsr_pkg::*;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cke, cs_n, ras_n, cas_n, we_n, self_refresh, dll_enable, read_allowed, refresh_busy;
  logic [2:0] bank;
  logic [13:0] addr;
  logic [1:0] odt_sel;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  dsr_ctl_model i_ctl (.mclk(mclk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .bank(bank), .addr(addr));
  dsr_self_refresh_ctrl i_dut (.mclk(mclk), .reset(reset), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bank(bank), .addr(addr), .self_refresh(self_refresh),
    .dll_enable(dll_enable), .read_allowed(read_allowed), .refresh_busy(refresh_busy), .odt_sel(odt_sel));
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      num_errors++;
      results();
    end
  end
  task results();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wait_cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // ----
  // Scenarios
  // ----
  task t_reset();
    check("reset state", 8'({self_refresh, dll_enable, read_allowed, refresh_busy, odt_sel}), 8'h18);
  endtask
  task t_odt();
    logic [13:0] a;
    for (int i = 0; i < 4; i++)
    begin
      a = 14'h0000;
      a[ODT_HI_BIT] = i[1];
      a[ODT_LO_BIT] = i[0];
      i_ctl.send(1'b1, CMD_MODE_SET, EMR_BANK, a);
      wait_cycles(3);
      check("odt_sel", 8'(odt_sel), 8'(i));
    end
    i_ctl.send(1'b1, CMD_MODE_SET, 3'h0, 14'h0004);
    wait_cycles(3);
    check("odt_sel other bank", 8'(odt_sel), 8'h03);
  endtask
  task t_self_refresh();
    logic seen;
    int n;
    seen = 1'b0;
    n = 0;
    i_ctl.enter();
    wait_cycles(3);
    check("entry", 8'({self_refresh, dll_enable, read_allowed}), 8'h04);
    repeat (INT_REFRESH_CYCLES + 20)
    begin
      i_ctl.wander(1);
      seen = seen | refresh_busy;
    end
    check("internal refresh", 8'(seen), 8'h01);
    check("odt held", 8'(odt_sel), 8'h03);
    i_ctl.glitch();
    wait_cycles(10);
    check("short cke high", 8'(self_refresh), 8'h01);
    i_ctl.leave();
    while (dll_enable !== 1'b1 && n < 20)
    begin
      wait_cycles(1);
      n++;
    end
    check("exit delay", 8'(n), 8'h07);
    check("exit", 8'({self_refresh, read_allowed}), 8'h00);
    wait_cycles(DLL_RELOCK_CYCLES - 1);
    check("read before relock", 8'(read_allowed), 8'h00);
    wait_cycles(1);
    check("read after relock", 8'(read_allowed), 8'h01);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    #1;
    reset = 1'b0;
    wait_cycles(3);
    t_reset();
    t_odt();
    t_self_refresh();
    results();
  end
endmodule
